// ### bench/ext_clock_source.sv
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Clock source on the shared count pin: bursts of pulses, parked level between them
module ext_clock_source (
   input wire logic mclk,
   input wire logic park,
   input wire logic go,
   input wire logic [7:0] pulses,
   input wire logic [3:0] half,
   output logic pin,
   output logic busy
);
   timeunit 1ns;
   timeprecision 1ns;

   logic [7:0] left_q = 8'h00;
   logic [3:0] tmr_q = 4'h0;
   logic lvl_q = 1'b0;

   // Each pulse is a low phase then a high phase, so a burst opens with a falling edge;
   // phases of at least two cycles keep each level visible through the input synchroniser
   always @(posedge mclk) begin
      if (go) begin
         left_q <= pulses;
         tmr_q <= half;
         lvl_q <= 1'b0;
      end else if (left_q != 8'h00) begin
         if (tmr_q > 4'h1) begin
            tmr_q <= tmr_q - 4'h1;
         end else begin
            tmr_q <= half;
            lvl_q <= ~lvl_q;
            if (lvl_q) begin
               left_q <= left_q - 8'h01;
            end
         end
      end
   end

   assign busy = (left_q != 8'h00);
   assign pin = busy ? lvl_q : park;
endmodule // ext_clock_source

`default_nettype wire

// ### bench/sixteen_bit_timer_counter_three_bench.sv
`default_nettype none
`include "timer_counter_consts.svh"

module sixteen_bit_timer_counter_three_bench import timer_counter_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ns;

   logic mclk;
   logic rst_b;
   bus_req_t bus_req;
   logic [7:0] bus_rdata;
   logic pin;
   logic irq;
   logic overflow_pulse;
   logic park;
   logic go;
   logic [7:0] pulses;
   logic [3:0] half;
   logic busy;
   int mismatches;
   int n_checks;
   int k;
   logic [7:0] d;
   // External cases: control value, pulses sent, count expected
   logic [7:0] ec [7] = '{8'h03, 8'h07, 8'h17, 8'h27, 8'h06, 8'h37, 8'h37};
   logic [7:0] en [7] = '{8'h05, 8'h05, 8'h06, 8'h08, 8'h05, 8'h04, 8'h04};
   logic [7:0] ee [7] = '{8'h05, 8'h05, 8'h03, 8'h02, 8'h00, 8'h00, 8'h00};

   timer_counter #(.INSTR_DIV(4)) dut (
      .mclk(mclk), .rst_b(rst_b), .bus_req(bus_req), .bus_rdata(bus_rdata),
      .shared_ext_clock_pin(pin), .irq(irq), .overflow_pulse(overflow_pulse));

   ext_clock_source src (
      .mclk(mclk), .park(park), .go(go), .pulses(pulses), .half(half), .pin(pin), .busy(busy));

   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic results();
      $display("checks %0d, mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic give_up(input string why);
      mismatches++;
      $display("unexpected at %0t: %s", $time, why);
      results();
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] v);
      @(posedge mclk);
      bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge mclk);
      bus_req.wr <= 1'b0;
   endtask

   // Read data stands only in the cycle after the strobe
   task automatic rd(input logic [11:0] a, output logic [7:0] v);
      @(posedge mclk);
      bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge mclk);
      bus_req.rd <= 1'b0;
      #1;
      v = bus_rdata;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: %s is %h, expected %h", $time, what, got, exp);
      end
   endtask

   task automatic chk_rd(input logic [11:0] a, input logic [7:0] exp, input string what);
      logic [7:0] v;
      rd(a, v);
      chk(v, exp, what);
   endtask

   task automatic chk_lvl(input logic got, input logic exp, input string what);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: %s is %b, expected %b", $time, what, got, exp);
      end
   endtask

   task automatic chk_rng(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi, input string what);
      n_checks++;
      if ((got >= lo && got <= hi) !== 1'b1) begin
         mismatches++;
         $display("unexpected at %0t: %s is %h, expected %h to %h", $time, what, got, lo, hi);
      end
   endtask

   // Pin parked low before the source is picked, then raised: that rise has no falling edge before it
   task automatic ext(input logic [7:0] ctrl, input logic [7:0] n, output logic [7:0] got);
      int i;
      park <= 1'b0;
      repeat (6) @(posedge mclk);
      wr(`OFF_CTRL, ctrl);
      wr(`OFF_CNT_LOW, 8'h00);
      wr(`OFF_CNT_HIGH, 8'h00);
      park <= 1'b1;
      repeat (6) @(posedge mclk);
      go <= 1'b1;
      pulses <= n;
      @(posedge mclk);
      go <= 1'b0;
      @(posedge mclk);
      for (i = 0; i < 300 && busy !== 1'b0; i++) @(posedge mclk);
      if (busy !== 1'b0) give_up("pulse burst never ended");
      repeat (12) @(posedge mclk);
      rd(`OFF_CNT_LOW, got);
      wr(`OFF_CTRL, 8'h00);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      int i;
      bus_req = '0;
      park = 1'b1;
      go = 1'b0;
      pulses = 8'h00;
      half = 4'h4;
      rst_b = 1'b0;
      mismatches = 0;
      n_checks = 0;
      repeat (12) @(posedge mclk);
      rst_b <= 1'b1;
      chk_rd(`OFF_CTRL, 8'h00, "control");
      chk_rd(`OFF_CNT_LOW, 8'h00, "count low");
      chk_rd(`OFF_CNT_HIGH, 8'h00, "count high");
      chk_rd(`OFF_IRQ_STATUS, 8'h00, "status");
      chk_rd(`OFF_IRQ_MASK, 8'h00, "mask");
      chk_rd(12'hFB0, 8'h00, "unmapped");
      chk_lvl(irq, 1'b0, "irq");
      wr(`OFF_CTRL, 8'hB4);
      chk_rd(`OFF_CTRL, 8'hB4, "control");
      wr(`OFF_CTRL, 8'h00);
      $display("test registers done");
      wr(`OFF_CNT_LOW, 8'h5A);
      wr(`OFF_CNT_HIGH, 8'hC3);
      chk_rd(`OFF_CNT_LOW, 8'h5A, "byte low");
      chk_rd(`OFF_CNT_HIGH, 8'hC3, "byte high");
      wr(`OFF_CTRL, 8'h80);
      wr(`OFF_CNT_HIGH, 8'h12);
      wr(`OFF_CNT_LOW, 8'h34);
      chk_rd(`OFF_CNT_LOW, 8'h34, "wide low");
      chk_rd(`OFF_CNT_HIGH, 8'h12, "wide high");
      wr(`OFF_CNT_HIGH, 8'h77);
      chk_rd(`OFF_CNT_LOW, 8'h34, "wide low");
      chk_rd(`OFF_CNT_HIGH, 8'h12, "wide high");
      wr(`OFF_CTRL, 8'h00);
      chk_rd(`OFF_CNT_HIGH, 8'h12, "byte high");
      $display("test access modes done");
      // Sync-disable set on purpose: the internal source must ignore it
      for (k = 0; k < 4; k++) begin
         wr(`OFF_CNT_LOW, 8'h00);
         wr(`OFF_CNT_HIGH, 8'h00);
         wr(`OFF_CTRL, {2'b00, k[1:0], 4'h5});
         repeat (64) @(posedge mclk);
         wr(`OFF_CTRL, 8'h00);
         rd(`OFF_CNT_LOW, d);
         chk_rng(d, (8'h10 >> k) - 8'h01, (8'h10 >> k) + 8'h01, "timer count");
      end
      $display("test timer done");
      for (k = 0; k < 7; k++) begin
         ext(ec[k], en[k], d);
         chk(d, ee[k], "external count");
      end
      $display("test external done");
      wr(`OFF_CNT_HIGH, 8'hFF);
      wr(`OFF_CNT_LOW, 8'hFE);
      wr(`OFF_CTRL, 8'h01);
      // Sample after the edge so the pulse is seen in the cycle it stands
      for (i = 0; i < 40 && overflow_pulse !== 1'b1; i++) begin
         @(posedge mclk);
         #1;
      end
      if (overflow_pulse !== 1'b1) give_up("no overflow pulse");
      chk_lvl(irq, 1'b0, "masked irq");
      @(posedge mclk);
      #1;
      chk_lvl(overflow_pulse, 1'b0, "overflow pulse length");
      wr(`OFF_CTRL, 8'h00);
      chk_rd(`OFF_CNT_HIGH, 8'h00, "wrapped high");
      repeat (20) @(posedge mclk);
      chk_rd(`OFF_IRQ_STATUS, 8'h01, "status");
      wr(`OFF_IRQ_MASK, 8'h01);
      #1;
      chk_lvl(irq, 1'b1, "unmasked irq");
      wr(`OFF_IRQ_STATUS, 8'h01);
      #1;
      chk_lvl(irq, 1'b0, "cleared irq");
      chk_rd(`OFF_IRQ_STATUS, 8'h00, "status");
      $display("test overflow done");
      results();
   end
endmodule // sixteen_bit_timer_counter_three_bench

`default_nettype wire

// ### rtl/timer_counter.sv
// Local design decision: strobed register access.
`default_nettype none
`include "timer_counter_consts.svh"

////////////////////////////////////////////////////////////////////////////////
module timer_counter
   import timer_counter_pkg::*;
#(
   parameter int INSTR_DIV = `INSTR_DIV_DEFAULT
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire bus_req_t bus_req,
   output logic [7:0] bus_rdata,
   input wire logic shared_ext_clock_pin,
   output logic irq,
   output logic overflow_pulse
);

   if (INSTR_DIV < 1 || INSTR_DIV > 256) begin : g_bad_div
      $error("INSTR_DIV must lie between 1 and 256");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   function automatic logic addr_hit(input logic [11:0] addr, input logic [11:0] off);
      return addr == off;
   endfunction

   function automatic count_mode_t decode_mode(input timer_control_t c);
      count_mode_t m;
      m = MODE_TIMER;
      if (c.clock_source_select) begin
         m = c.ext_clock_sync_disable ? MODE_ASYNC_COUNTER : MODE_SYNC_COUNTER;
      end
      return m;
   endfunction

   function automatic logic [2:0] prescale_mask(input logic [1:0] ps);
      logic [2:0] m;
      m = 3'h0;
      case (ps)
         2'b00: m = 3'h0;
         2'b01: m = 3'h1;
         2'b10: m = 3'h3;
         2'b11: m = 3'h7;
         default: m = 3'h0;
      endcase
      return m;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Declarations

   timer_control_t ctrl_q;
   count_mode_t mode;
   logic [7:0] div_q;
   logic instr_tick;
   logic ext_s1_q, ext_s2_q, ext_s3_q;
   logic ext_rise, ext_fall, ext_edge;
   logic armed_q;
   logic pend_q;
   logic src_evt;
   logic [2:0] pre_q;
   logic [2:0] pre_mask;
   logic pre_done;
   logic cnt_tick;
   logic [15:0] cnt_q;
   logic [7:0] hbuf_q;
   logic [7:0] status_q;
   logic [7:0] mask_q;
   logic [7:0] status_set;
   logic [7:0] status_clr;
   logic [7:0] rd_val;
   logic [7:0] rdata_q;
   logic ovf_q;
   logic sel_ctrl, sel_low, sel_high, sel_stat, sel_mask;
   logic wr_low, wr_high, cnt_wr, wrap;

   ////////////////////////////////////////////////////////////////////////////
   // Address decode

   assign sel_ctrl = addr_hit(bus_req.addr, `OFF_CTRL);
   assign sel_low = addr_hit(bus_req.addr, `OFF_CNT_LOW);
   assign sel_high = addr_hit(bus_req.addr, `OFF_CNT_HIGH);
   assign sel_stat = addr_hit(bus_req.addr, `OFF_IRQ_STATUS);
   assign sel_mask = addr_hit(bus_req.addr, `OFF_IRQ_MASK);

   assign wr_low = bus_req.wr & sel_low;
   assign wr_high = bus_req.wr & sel_high;
   // In wide mode a high write only fills the buffer
   assign cnt_wr = wr_low | (wr_high & ~ctrl_q.wide_access_select);

   ////////////////////////////////////////////////////////////////////////////
   // Control register

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         ctrl_q <= timer_control_t'(`CTRL_RESET);
      end else if (bus_req.wr && sel_ctrl) begin
         // Unimplemented bits never store, so they read as zero
         ctrl_q <= timer_control_t'(bus_req.wdata & `CTRL_WMASK);
      end
   end

   assign mode = decode_mode(ctrl_q);

   ////////////////////////////////////////////////////////////////////////////
   // Instruction clock divider

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         div_q <= 8'h00;
      end else if (instr_tick) begin
         div_q <= 8'h00;
      end else begin
         div_q <= div_q + 8'h01;
      end
   end

   assign instr_tick = (div_q == 8'(INSTR_DIV - 1));

   ////////////////////////////////////////////////////////////////////////////
   // External clock pin

   // Three flops even in unsynchronised mode: the pin is foreign to mclk
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         ext_s1_q <= 1'b0;
         ext_s2_q <= 1'b0;
         ext_s3_q <= 1'b0;
      end else begin
         ext_s1_q <= shared_ext_clock_pin;
         ext_s2_q <= ext_s1_q;
         ext_s3_q <= ext_s2_q;
      end
   end

   assign ext_rise = ext_s2_q & ~ext_s3_q;
   assign ext_fall = ~ext_s2_q & ext_s3_q;

   // A pin sitting high at selection time must not count at once
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         armed_q <= 1'b0;
      end else if (!ctrl_q.clock_source_select) begin
         armed_q <= 1'b0;
      end else if (ext_fall) begin
         armed_q <= 1'b1;
      end
   end

   assign ext_edge = armed_q & ext_rise;

   // Synchronous counter holds an edge until the next instruction cycle
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         pend_q <= 1'b0;
      end else if (mode != MODE_SYNC_COUNTER) begin
         pend_q <= 1'b0;
      end else if (instr_tick) begin
         pend_q <= 1'b0;
      end else if (ext_edge) begin
         pend_q <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Count source selection

   always_comb begin
      src_evt = 1'b0;
      case (mode)
         MODE_TIMER: src_evt = instr_tick;
         MODE_SYNC_COUNTER: src_evt = instr_tick & (pend_q | ext_edge);
         MODE_ASYNC_COUNTER: src_evt = ext_edge;
         default: src_evt = 1'b0;
      endcase
      src_evt = src_evt & ctrl_q.timer_run;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Prescaler

   assign pre_mask = prescale_mask({ctrl_q.prescale_select_hi, ctrl_q.prescale_select_lo});
   assign pre_done = (pre_q & pre_mask) == pre_mask;
   assign cnt_tick = src_evt & pre_done;

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         pre_q <= 3'h0;
      end else if (cnt_wr) begin
         pre_q <= 3'h0;
      end else if (src_evt) begin
         pre_q <= pre_done ? 3'h0 : pre_q + 3'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Counter and high byte buffer

   // A software write wins over a count in the same cycle
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         cnt_q <= `CNT_RESET;
      end else if (wr_low) begin
         if (ctrl_q.wide_access_select) begin
            cnt_q <= {hbuf_q, bus_req.wdata};
         end else begin
            cnt_q <= {cnt_q[15:8], bus_req.wdata};
         end
      end else if (wr_high && !ctrl_q.wide_access_select) begin
         cnt_q <= {bus_req.wdata, cnt_q[7:0]};
      end else if (cnt_tick) begin
         cnt_q <= cnt_q + 16'h0001;
      end
   end

   // One buffer serves both directions; strobes never coincide
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         hbuf_q <= 8'h00;
      end else if (ctrl_q.wide_access_select && bus_req.rd && sel_low) begin
         hbuf_q <= cnt_q[15:8];
      end else if (ctrl_q.wide_access_select && wr_high) begin
         hbuf_q <= bus_req.wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Overflow interrupt

   assign wrap = cnt_tick & (cnt_q == `CNT_MAX) & ~cnt_wr;
   assign status_set = {7'h00, wrap};
   assign status_clr = (bus_req.wr && sel_stat) ? (bus_req.wdata & `IRQ_WMASK) : 8'h00;

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         status_q <= `IRQ_RESET;
      end else begin
         // Set wins over clear so no wrap is lost
         status_q <= (status_q & ~status_clr) | status_set;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         mask_q <= `IRQ_RESET;
      end else if (bus_req.wr && sel_mask) begin
         mask_q <= bus_req.wdata & `IRQ_WMASK;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         ovf_q <= 1'b0;
      end else begin
         ovf_q <= wrap;
      end
   end

   assign irq = |(status_q & mask_q);
   assign overflow_pulse = ovf_q;

   ////////////////////////////////////////////////////////////////////////////
   // Read port

   always_comb begin
      rd_val = 8'h00;
      if (sel_ctrl) begin
         rd_val = ctrl_q & `CTRL_WMASK;
      end else if (sel_low) begin
         rd_val = cnt_q[7:0];
      end else if (sel_high) begin
         rd_val = ctrl_q.wide_access_select ? hbuf_q : cnt_q[15:8];
      end else if (sel_stat) begin
         rd_val = status_q;
      end else if (sel_mask) begin
         rd_val = mask_q;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= bus_req.rd ? rd_val : 8'h00;
      end
   end

   assign bus_rdata = rdata_q;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);

   a_wrap_raises_flag: assert property (
      (cnt_tick && cnt_q == `CNT_MAX && !cnt_wr) |=> (cnt_q == 16'h0000 && status_q[0] && overflow_pulse)
   ) else $error("wrap did not zero count and set overflow flag");

   a_flag_sticky: assert property (
      (status_q[0] && !(bus_req.wr && sel_stat && bus_req.wdata[0])) |=> status_q[0]
   ) else $error("overflow flag dropped without a clear");

   a_run_holds_count: assert property (
      (!ctrl_q.timer_run && !bus_req.wr) |=> $stable(cnt_q)
   ) else $error("count moved while stopped");

   a_prescale_gate: assert property (
      (cnt_tick && !cnt_wr) |=> (pre_q == 3'h0)
   ) else $error("prescaler did not restart after a count");

   a_div8_spacing: assert property (
      (cnt_tick && mode == MODE_TIMER && ctrl_q.prescale_select_hi && ctrl_q.prescale_select_lo
       && !bus_req.wr) |=> !cnt_tick [*8]
   ) else $error("1:8 prescale ticked too soon");

   a_internal_rate: assert property (
      (mode == MODE_TIMER && ctrl_q.timer_run && pre_mask == 3'h0) |-> (cnt_tick == instr_tick)
   ) else $error("internal source not counting every instruction cycle");

   a_arm_first_fall: assert property (
      (!armed_q && mode != MODE_TIMER) |-> !src_evt
   ) else $error("external edge counted before a falling edge");

   a_sync_on_tick: assert property (
      (mode == MODE_SYNC_COUNTER && src_evt) |-> instr_tick
   ) else $error("synchronised count off the instruction cycle");

   a_wide_latch: assert property (
      (ctrl_q.wide_access_select && bus_req.rd && sel_low) ##1 !bus_req.wr ##1 (bus_req.rd && sel_high)
      |=> bus_rdata == $past(cnt_q[15:8], 3)
   ) else $error("wide read did not return latched high byte");

   a_wide_write: assert property (
      (ctrl_q.wide_access_select && wr_high && !ctrl_q.timer_run) |=> $stable(cnt_q)
   ) else $error("wide high write reached the counter early");

   a_ctrl_readback: assert property (
      (bus_req.rd && sel_ctrl) |=> bus_rdata == ($past(ctrl_q) & 8'hB7)
   ) else $error("control readback mismatch");

   a_write_clears_pre: assert property (
      cnt_wr |=> pre_q == 3'h0
   ) else $error("count write left prescaler running");

   c_async_wrap: cover property (mode == MODE_ASYNC_COUNTER && wrap);
   c_sync_count: cover property (mode == MODE_SYNC_COUNTER && cnt_tick);
   c_wide_read: cover property ((bus_req.rd && sel_low && ctrl_q.wide_access_select) ##2 (bus_req.rd && sel_high));
   c_irq_fire: cover property ($rose(irq));

endmodule // timer_counter

`default_nettype wire

// ### rtl/timer_counter_consts.svh
`ifndef TIMER_COUNTER_CONSTS_SVH
`define TIMER_COUNTER_CONSTS_SVH

// Register byte addresses on the 12-bit register port
`define OFF_CTRL 12'hFB1
`define OFF_CNT_LOW 12'hFB2
`define OFF_CNT_HIGH 12'hFB3
`define OFF_IRQ_STATUS 12'hFB4
`define OFF_IRQ_MASK 12'hFB5

// Control field positions
`define CTRL_BIT_WIDE 7
`define CTRL_BIT_PS_HI 5
`define CTRL_BIT_PS_LO 4
`define CTRL_BIT_SYNC_DIS 2
`define CTRL_BIT_SRC 1
`define CTRL_BIT_RUN 0

// Bits 6 and 3 are not implemented
`define CTRL_WMASK 8'hB7

// Interrupt status and mask layout
`define IRQ_BIT_OVF 0
`define IRQ_WMASK 8'h01

// Reset values
`define CTRL_RESET 8'h00
`define CNT_RESET 16'h0000
`define IRQ_RESET 8'h00

// Count limits
`define CNT_MAX 16'hFFFF

// Instruction cycle is the oscillator divided by four
`define INSTR_DIV_DEFAULT 4

`endif

// ### rtl/timer_counter_pkg.sv
`default_nettype none

package timer_counter_pkg;

   typedef struct packed {
      logic wide_access_select;
      logic unused6;
      logic prescale_select_hi;
      logic prescale_select_lo;
      logic unused3;
      logic ext_clock_sync_disable;
      logic clock_source_select;
      logic timer_run;
   } timer_control_t;

   typedef struct packed {
      logic [11:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } bus_req_t;

   typedef enum logic [1:0] {
      MODE_TIMER = 2'b00,
      MODE_SYNC_COUNTER = 2'b01,
      MODE_ASYNC_COUNTER = 2'b10
   } count_mode_t;

endpackage : timer_counter_pkg

`default_nettype wire
